//--- pkg/cansip_params.svh
// constants of the sync, interrupt code and power control block
// assumes a 32-bit apb slave and a byte-wide status view
// How it works
// RQ1: resync on recessive-to-dominant edge after sample
// RQ2: other edges resync only when not sending dominant
// RQ3: hard sync restarts bit at sync segment
// RQ4: resync adjusts bit by at most jump+1
// RQ5: software keeps segment minimums and jump limits
// RQ6: software keeps total bit time eight quanta
// RQ7: one irq line, gated by source enables; here only GIE gates the line, object sources have no enable
// RQ8: code reads zero when nothing pends
// RQ9: line active while code nonzero and enabled
// RQ10: lowest pending code always shown
// RQ11: status update raises code one
// RQ12: status writes no irq; status read clears
// RQ13: last object pending gives code two
// RQ14: object n pending gives code two plus n
// RQ15: software clears object pending flags
// RQ16: idle keeps running; enabled irq wakes cpu
// RQ17: slow-down divides controller clock by 32
// RQ18: software sets init before power-down
// RQ19: receive pin wakes power-down when selected
// RQ20: switch-off bit gates controller clock
// RQ21: sync segment fixed at one quantum
// RQ22: low is dominant, high recessive
// RQ23: code recomputed every clock
`ifndef CANSIP_PARAMS_SVH
`define CANSIP_PARAMS_SVH
`define CANSIP_OFS_CTRL 12'h000
`define CANSIP_OFS_STAT 12'h004
`define CANSIP_OFS_CODE 12'h008
`define CANSIP_OFS_BTIM 12'h00C
`define CANSIP_OFS_PEND 12'h010
`define CANSIP_OFS_PWR 12'h014
`define CANSIP_CTRL_RST 8'h01
`define CANSIP_CTRL_INIT 0
`define CANSIP_CTRL_GIE 1
`define CANSIP_CTRL_SIE 2
`define CANSIP_CTRL_EIE 3
`define CANSIP_ST_TRANSMIT_OK_FLAG 3
`define CANSIP_ST_RECEIVE_OK_FLAG 4
`define CANSIP_ST_ERROR_WARNING_FLAG 6
`define CANSIP_ST_BUS_OFF_FLAG 7
`define CANSIP_PWR_SLOW 0
`define CANSIP_PWR_OFF 1
`define CANSIP_PWR_WAKE 2
`define CANSIP_BT_RST 16'h2343
`define CANSIP_SLOW_DIV 6'h20
`define CANSIP_SYNC_TQ 4'h1
`define CANSIP_CODE_IDLE 5'h00
`define CANSIP_CODE_STAT 5'h01
`define CANSIP_CODE_LAST 5'h02
`define CANSIP_LAST_OBJ 15
`define CANSIP_DOMINANT 1'b0
`define CANSIP_RECESSIVE 1'b1
`endif

//--- pkg/cansip_pkg.sv
// types of the sync, interrupt code and power control block
// assumes the constants header is included by each design file
package cansip_pkg;
  // bit segment states, gray along sync, pre, post
  typedef enum logic [1:0] {
    CANSIP_SEG_SYNC = 2'b00,
    CANSIP_SEG_PRE = 2'b01,
    CANSIP_SEG_POST = 2'b11
  } cansip_seg_t;
endpackage

//--- hdl/cansip_clkgen.sv
// controller clock enable: full rate, one in 32, or stopped
// assumes mclk_in is the system clock and all inputs are synchronous
`include "cansip_params.svh"
module cansip_clkgen
  import cansip_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // control
  input wire logic slow_down_in,
  input wire logic gate_off_in,
  // tick
  output logic tick_out
);
  logic [5:0] div_q;
  logic [5:0] div_d;

  always_comb begin
    div_d = div_q + 6'h01;
    if (div_d == `CANSIP_SLOW_DIV) begin
      div_d = 6'h00;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      div_q <= 6'h00;
    end else if (clk_en_in) begin
      div_q <= div_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      tick_out <= 1'b0;
    end else if (clk_en_in) begin
      if (gate_off_in) begin
        tick_out <= 1'b0; // see RQ20
      end else if (slow_down_in) begin
        tick_out <= (div_q == 6'h00); // see RQ17
      end else begin
        tick_out <= 1'b1;
      end
    end
  end
endmodule

//--- hdl/cansip_core.sv
// bit synchronisation, interrupt code and power control with apb registers
// assumes a protocol engine supplies tx bits and status events, and message
// objects supply pending set pulses; power-down and idle come from the cpu
//
// The APB interface to the registers and the register offsets were decided locally.
`include "cansip_params.svh"
module cansip_core
  import cansip_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // can pins
  input wire logic can_rx_pin_in,
  output logic can_tx_pin_out,
  // protocol engine
  input wire logic tx_bit_in,
  input wire logic hard_sync_en_in,
  output logic sample_point_out,
  output logic rx_bit_out,
  // status events
  input wire logic receive_ok_in,
  input wire logic transmit_ok_in,
  input wire logic lec_upd_in,
  input wire logic [2:0] last_error_code_in,
  input wire logic bus_off_flag_in,
  input wire logic error_warning_flag_in,
  // message object pending set pulses
  input wire logic [15:1] obj_pend_set_in,
  // cpu power states
  input wire logic cpu_idle_in,
  input wire logic cpu_power_down_in,
  input wire logic can_irq_gate_in,
  // interrupt and wake
  output logic irq_out,
  output logic idle_wake_out,
  output logic pd_wake_out,
  output logic [4:0] interrupt_code_out
);
  logic [7:0] ctrl_q;
  logic [15:0] btim_q;
  logic [2:0] pwr_q;
  logic [2:0] lec_q;
  logic rx_ok_q;
  logic tx_ok_q;
  logic bus_off_flag_q;
  logic error_warning_flag_q;
  logic stat_pend_q;
  logic [15:1] object_irq_pending_q;
  logic [4:0] code_d;
  logic tick;
  logic acc;
  logic wr;
  logic rd;
  logic stat_ev;
  logic [31:0] rdata_d;
  logic map_hit;
  // bit timing fields
  logic [5:0] brp;
  logic [1:0] resync_jump_width;
  logic [3:0] pre_sample_segment;
  logic [2:0] post_sample_segment;
  // bit timing state
  cansip_seg_t seg_q;
  logic [5:0] pre_q;
  logic [4:0] seg_cnt_q;
  logic [4:0] seg_len_q;
  logic rx_prev_q;
  logic tq_tick;
  logic edge_r2d;
  logic sync_ok;
  logic [4:0] sjw1;
  logic [4:0] remain;

  assign brp = btim_q[5:0];
  assign resync_jump_width = btim_q[7:6];
  assign pre_sample_segment = btim_q[11:8];
  assign post_sample_segment = btim_q[14:12];
  assign sjw1 = {3'b000, resync_jump_width} + 5'h01;

  // controller clock enable, stopped by switch-off or power-down
  cansip_clkgen u_clkgen (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .slow_down_in(pwr_q[`CANSIP_PWR_SLOW]),
    .gate_off_in(pwr_q[`CANSIP_PWR_OFF] | cpu_power_down_in),
    .tick_out(tick)
  );

  // apb: access phase takes two cycles, ready from a flop
  assign acc = psel_in & penable_in & pready_out;
  assign wr = acc & pwrite_in;
  assign rd = acc & ~pwrite_in;

  always_comb begin
    map_hit = 1'b1;
    rdata_d = 32'h0000_0000;
    case (paddr_in)
      `CANSIP_OFS_CTRL: rdata_d = {24'h000000, ctrl_q};
      `CANSIP_OFS_STAT: rdata_d = {24'h000000, bus_off_flag_q, error_warning_flag_q, 1'b0, rx_ok_q, tx_ok_q, lec_q};
      `CANSIP_OFS_CODE: rdata_d = {27'h0000000, interrupt_code_out};
      `CANSIP_OFS_BTIM: rdata_d = {16'h0000, btim_q};
      `CANSIP_OFS_PEND: rdata_d = {16'h0000, object_irq_pending_q, 1'b0};
      `CANSIP_OFS_PWR: rdata_d = {29'h00000000, pwr_q};
      default: map_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else if (clk_en_in) begin
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~map_hit;
      if (psel_in & penable_in & ~pready_out) begin
        prdata_out <= pwrite_in ? 32'h0000_0000 : rdata_d;
      end
    end
  end

  // control, bit timing and power registers
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ctrl_q <= `CANSIP_CTRL_RST;
      btim_q <= `CANSIP_BT_RST;
      pwr_q <= 3'b000;
    end else if (clk_en_in && wr) begin
      if (paddr_in == `CANSIP_OFS_CTRL) begin
        ctrl_q <= pwdata_in[7:0];
      end
      if (paddr_in == `CANSIP_OFS_BTIM && ctrl_q[`CANSIP_CTRL_INIT]) begin
        btim_q <= pwdata_in[15:0];
      end
      if (paddr_in == `CANSIP_OFS_PWR) begin
        pwr_q <= pwdata_in[2:0]; // see RQ17 see RQ19 see RQ20
      end
    end
  end

  // status partition: writes may clear flags but touch no interrupt
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      lec_q <= 3'b000;
      rx_ok_q <= 1'b0;
      tx_ok_q <= 1'b0;
      bus_off_flag_q <= 1'b0;
      error_warning_flag_q <= 1'b0;
    end else if (clk_en_in) begin
      bus_off_flag_q <= bus_off_flag_in;
      error_warning_flag_q <= error_warning_flag_in;
      if (wr && paddr_in == `CANSIP_OFS_STAT) begin
        lec_q <= lec_q & pwdata_in[2:0]; // see RQ12
        rx_ok_q <= rx_ok_q & pwdata_in[`CANSIP_ST_RECEIVE_OK_FLAG];
        tx_ok_q <= tx_ok_q & pwdata_in[`CANSIP_ST_TRANSMIT_OK_FLAG];
      end
      if (lec_upd_in) begin
        lec_q <= last_error_code_in;
      end
      if (receive_ok_in) begin
        rx_ok_q <= 1'b1;
      end
      if (transmit_ok_in) begin
        tx_ok_q <= 1'b1;
      end
    end
  end

  // status change event under the source enables
  assign stat_ev = (ctrl_q[`CANSIP_CTRL_EIE] &
                    ((bus_off_flag_q ^ bus_off_flag_in) | (error_warning_flag_q ^ error_warning_flag_in))) |
                   (ctrl_q[`CANSIP_CTRL_SIE] & (receive_ok_in | transmit_ok_in | lec_upd_in));

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      stat_pend_q <= 1'b0;
    end else if (clk_en_in) begin
      if (stat_ev) begin
        stat_pend_q <= 1'b1; // see RQ11
      end else if (rd && paddr_in == `CANSIP_OFS_STAT) begin
        stat_pend_q <= 1'b0; // see RQ12
      end
    end
  end

  // object pending: hardware set wins over write-one-to-clear
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      object_irq_pending_q <= 15'h0000;
    end else if (clk_en_in) begin
      if (wr && paddr_in == `CANSIP_OFS_PEND) begin
        object_irq_pending_q <= (object_irq_pending_q & ~pwdata_in[15:1]) | obj_pend_set_in;
      end else begin
        object_irq_pending_q <= object_irq_pending_q | obj_pend_set_in;
      end
    end
  end

  // priority encode, lowest code wins
  always_comb begin
    code_d = `CANSIP_CODE_IDLE; // see RQ8
    for (int n = `CANSIP_LAST_OBJ - 1; n >= 1; n--) begin
      if (object_irq_pending_q[n]) begin
        code_d = 5'(n) + `CANSIP_CODE_LAST; // see RQ14
      end
    end
    if (object_irq_pending_q[`CANSIP_LAST_OBJ]) begin
      code_d = `CANSIP_CODE_LAST; // see RQ13
    end
    if (stat_pend_q) begin
      code_d = `CANSIP_CODE_STAT; // see RQ10
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      interrupt_code_out <= `CANSIP_CODE_IDLE;
      irq_out <= 1'b0;
      idle_wake_out <= 1'b0;
      pd_wake_out <= 1'b0;
    end else if (clk_en_in) begin
      interrupt_code_out <= code_d; // see RQ23
      irq_out <= (code_d != `CANSIP_CODE_IDLE) & ctrl_q[`CANSIP_CTRL_GIE]; // see RQ7 see RQ9
      idle_wake_out <= cpu_idle_in & can_irq_gate_in & irq_out; // see RQ16
      pd_wake_out <= cpu_power_down_in & pwr_q[`CANSIP_PWR_WAKE] &
                     (can_rx_pin_in == `CANSIP_DOMINANT); // see RQ19
    end
  end

  // time quantum prescaler on the controller clock
  assign tq_tick = tick & (pre_q == brp);

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pre_q <= 6'h00;
    end else if (clk_en_in && tick) begin
      pre_q <= tq_tick ? 6'h00 : pre_q + 6'h01;
    end
  end

  // edge detect and resync permission
  assign edge_r2d = (rx_prev_q == `CANSIP_RECESSIVE) &
                    (can_rx_pin_in == `CANSIP_DOMINANT); // see RQ22
  assign sync_ok = (seg_q == CANSIP_SEG_POST) | // see RQ1
                   (can_tx_pin_out != `CANSIP_DOMINANT); // see RQ2
  assign remain = seg_len_q - seg_cnt_q;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rx_prev_q <= `CANSIP_RECESSIVE;
    end else if (clk_en_in && tq_tick) begin
      rx_prev_q <= can_rx_pin_in;
    end
  end

  // bit segment sequencer
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || (clk_en_in && ctrl_q[`CANSIP_CTRL_INIT])) begin
      seg_q <= CANSIP_SEG_SYNC;
      seg_cnt_q <= 5'h00;
      seg_len_q <= 5'h01;
      sample_point_out <= 1'b0;
    end else if (clk_en_in) begin
      sample_point_out <= 1'b0;
      if (tq_tick) begin
        seg_cnt_q <= seg_cnt_q + 5'h01;
        if (edge_r2d && hard_sync_en_in) begin
          seg_q <= CANSIP_SEG_PRE; // see RQ3
          seg_cnt_q <= 5'h00;
          seg_len_q <= {1'b0, pre_sample_segment} + 5'h01;
        end else if (edge_r2d && sync_ok && seg_q == CANSIP_SEG_PRE) begin
          // late edge: lengthen by the phase error, capped
          seg_len_q <= seg_len_q + ((seg_cnt_q < sjw1) ? seg_cnt_q : sjw1); // see RQ4
        end else if (edge_r2d && sync_ok && seg_q == CANSIP_SEG_POST) begin
          if (remain <= sjw1) begin
            seg_q <= CANSIP_SEG_PRE; // see RQ4
            seg_cnt_q <= 5'h00;
            seg_len_q <= {1'b0, pre_sample_segment} + 5'h01;
          end else begin
            seg_len_q <= seg_len_q - sjw1;
          end
        end else begin
          case (seg_q)
            CANSIP_SEG_SYNC: begin
              seg_q <= CANSIP_SEG_PRE; // see RQ21
              seg_cnt_q <= 5'h00;
              seg_len_q <= {1'b0, pre_sample_segment} + 5'h01;
            end
            CANSIP_SEG_PRE: begin
              if (seg_cnt_q + 5'h01 >= seg_len_q) begin
                seg_q <= CANSIP_SEG_POST;
                seg_cnt_q <= 5'h00;
                seg_len_q <= {2'b00, post_sample_segment} + 5'h01;
                sample_point_out <= 1'b1;
              end
            end
            CANSIP_SEG_POST: begin
              if (seg_cnt_q + 5'h01 >= seg_len_q) begin
                seg_q <= CANSIP_SEG_SYNC;
                seg_cnt_q <= 5'h00;
                seg_len_q <= {1'b0, `CANSIP_SYNC_TQ};
              end
            end
            default: begin
              seg_q <= CANSIP_SEG_SYNC;
              seg_cnt_q <= 5'h00;
            end
          endcase
        end
      end
    end
  end

  // sampled bit and transmit pin, recessive during init
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rx_bit_out <= `CANSIP_RECESSIVE;
      can_tx_pin_out <= `CANSIP_RECESSIVE;
    end else if (clk_en_in) begin
      if (tq_tick && seg_q == CANSIP_SEG_PRE && seg_cnt_q + 5'h01 >= seg_len_q) begin
        rx_bit_out <= can_rx_pin_in;
      end
      if (ctrl_q[`CANSIP_CTRL_INIT]) begin
        can_tx_pin_out <= `CANSIP_RECESSIVE; // see RQ18 see RQ22
      end else if (tq_tick && seg_q == CANSIP_SEG_SYNC) begin
        can_tx_pin_out <= tx_bit_in;
      end
    end
  end
endmodule

//--- tb/cansip_trx_model.sv
// bus transceiver model: wired-and bus, a remote node may pull dominant
// assumes the bench raises remote_dom_in to play the remote node
module cansip_trx_model (
  // local node
  input wire logic tx_in,
  // remote node
  input wire logic remote_dom_in,
  // bus
  output logic rx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up gives recessive, any dominant driver wins
  assign rx_out = tx_in & ~remote_dom_in;
endmodule

//--- tb/cansip_core_sva.sv
// port assertions for the sync, interrupt code and power block
// assumes one clock, synchronous reset, clock enable held high
module cansip_core_sva (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // inputs
  input wire logic can_rx_pin_in,
  input wire logic [15:1] obj_pend_set_in,
  input wire logic cpu_idle_in,
  input wire logic cpu_power_down_in,
  input wire logic can_irq_gate_in,
  // outputs
  input wire logic sample_point_out,
  input wire logic irq_out,
  input wire logic idle_wake_out,
  input wire logic pd_wake_out,
  input wire logic [4:0] interrupt_code_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  chk_irq_cause: assert property (irq_out |-> interrupt_code_out != 5'h00)
    else $error("irq line high without a code");
  chk_idle_quiet: assert property ((interrupt_code_out == 5'h00) [*2] |-> !irq_out)
    else $error("irq line high while code idle");
  chk_obj_last: assert property (obj_pend_set_in[15] |-> ##2
    interrupt_code_out inside {5'h01, 5'h02})
    else $error("last object code missing");
  chk_obj_low: assert property (obj_pend_set_in[1] |-> ##2
    (interrupt_code_out != 5'h00 && interrupt_code_out <= 5'h03))
    else $error("object one code missing");
  chk_code_range: assert property (interrupt_code_out <= 5'h10)
    else $error("code out of range");
  chk_idle_wake: assert property (idle_wake_out ==
    $past(cpu_idle_in && can_irq_gate_in && irq_out))
    else $error("idle wake mismatch");
  chk_pd_wake: assert property (pd_wake_out |-> $past(cpu_power_down_in && !can_rx_pin_in))
    else $error("power-down wake without dominant rx");
  chk_sample_pulse: assert property (sample_point_out |=> !sample_point_out)
    else $error("sample point wider than one cycle");
endmodule

bind cansip_core cansip_core_sva chk (.mclk_in, .sys_rst_in, .can_rx_pin_in,
  .obj_pend_set_in, .cpu_idle_in, .cpu_power_down_in, .can_irq_gate_in,
  .sample_point_out, .irq_out, .idle_wake_out, .pd_wake_out, .interrupt_code_out);

//--- tb/cansip_core_tb.sv
// self-checking bench for the sync, interrupt code and power block
// assumes a 125 MHz clock and the transceiver model on the bus pins
`include "cansip_params.svh"
module cansip_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in, sys_rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err;
  logic can_rx_pin_in, can_tx_pin_out, tx_bit_in, hard_sync_en_in, sample_point_out, dom;
  logic rx_bit_out, receive_ok_in, transmit_ok_in, lec_upd_in, bus_off_flag_in, irq_out;
  logic error_warning_flag_in, cpu_idle_in, cpu_power_down_in, can_irq_gate_in;
  logic idle_wake_out, pd_wake_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [2:0] last_error_code_in;
  logic [15:1] obj_pend_set_in;
  logic [4:0] interrupt_code_out;
  int n_fail, checks, nsp, n, m;
  time t0;
  cansip_core uut (.mclk_in, .sys_rst_in, .clk_en_in(1'b1), .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .can_rx_pin_in, .can_tx_pin_out, .tx_bit_in, .hard_sync_en_in, .sample_point_out,
    .rx_bit_out, .receive_ok_in, .transmit_ok_in, .lec_upd_in, .last_error_code_in,
    .bus_off_flag_in, .error_warning_flag_in, .obj_pend_set_in, .cpu_idle_in,
    .cpu_power_down_in, .can_irq_gate_in, .irq_out, .idle_wake_out, .pd_wake_out,
    .interrupt_code_out);
  cansip_trx_model trx (.tx_in(can_tx_pin_out), .remote_dom_in(dom), .rx_out(can_rx_pin_in));
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  always @(posedge sample_point_out) nsp++;
  task automatic end_sim;
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string w);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do @(posedge mclk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic cc(input logic [4:0] e);
    wt(2);
    chk(interrupt_code_out, e, "code");
  endtask
  task automatic evt(input logic [15:1] o, input logic r, input logic b);
    @(posedge mclk_in);
    obj_pend_set_in <= o;
    receive_ok_in <= r;
    bus_off_flag_in <= b;
    @(posedge mclk_in);
    obj_pend_set_in <= 15'h0000;
    receive_ok_in <= 1'b0;
    wt(3);
  endtask
  task automatic gap(output int g);
    @(posedge sample_point_out);
    t0 = $time;
    @(posedge sample_point_out);
    g = int'(($time - t0) / 8);
  endtask
  task automatic hs(input int k, output int g);
    @(posedge sample_point_out);
    repeat (k) @(posedge mclk_in);
    dom <= 1'b1;
    t0 = $time;
    @(posedge sample_point_out);
    g = int'(($time - t0) / 8);
    @(posedge mclk_in);
    dom <= 1'b0;
  endtask
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
  initial begin
    {psel_in, penable_in, pwrite_in, receive_ok_in, transmit_ok_in, lec_upd_in} = 6'h00;
    {bus_off_flag_in, error_warning_flag_in, cpu_idle_in, cpu_power_down_in} = 4'h0;
    {can_irq_gate_in, dom, hard_sync_en_in, tx_bit_in, sys_rst_in} = 5'h03;
    {paddr_in, pwdata_in, last_error_code_in, obj_pend_set_in} = 62'h0;
    {n_fail, checks, nsp} = 96'h0;
    repeat (6) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    apb(0, `CANSIP_OFS_CODE, 32'h0);
    chk(rd, 32'h0, "code read");
    apb(0, 12'hFFC, 32'h0);
    chk(err, 32'h1, "slverr");
    apb(1, `CANSIP_OFS_BTIM, 32'h2300);
    chk(can_tx_pin_out, 32'h1, "tx init");
    apb(1, `CANSIP_OFS_CTRL, 32'h0E);
    gap(n);
    chk(n, 8, "bit");
    apb(1, `CANSIP_OFS_PWR, 32'h1);
    gap(n);
    gap(n);
    chk(n, 256, "slow");
    apb(1, `CANSIP_OFS_PWR, 32'h0);
    hard_sync_en_in <= 1'b1;
    hs(1, n);
    hs(5, m);
    chk(n, m, "hard sync");
    chk(rx_bit_out, 32'h0, "rx bit");
    hard_sync_en_in <= 1'b0;
    hs(2, n);
    chk(n, m, "resync");
    apb(1, `CANSIP_OFS_PWR, 32'h2);
    m = nsp;
    wt(600);
    chk(nsp - m, 0, "switch off");
    apb(1, `CANSIP_OFS_PWR, 32'h0);
    apb(1, `CANSIP_OFS_CTRL, 32'h0F);
    apb(1, `CANSIP_OFS_PWR, 32'h4);
    @(posedge mclk_in);
    cpu_power_down_in <= 1'b1;
    dom <= 1'b1;
    wt(3);
    chk(pd_wake_out, 32'h1, "pd wake");
    @(posedge mclk_in);
    dom <= 1'b0;
    wt(3);
    chk(pd_wake_out, 32'h0, "pd quiet");
    @(posedge mclk_in);
    cpu_power_down_in <= 1'b0;
    apb(1, `CANSIP_OFS_CTRL, 32'h0E);
    evt(15'h0010, 1'b0, 1'b0);
    chk(interrupt_code_out, 32'h07, "obj five");
    evt(15'h4001, 1'b0, 1'b0);
    chk(interrupt_code_out, 32'h02, "obj last");
    chk(irq_out, 32'h1, "irq");
    @(posedge mclk_in);
    cpu_idle_in <= 1'b1;
    can_irq_gate_in <= 1'b1;
    wt(2);
    chk(idle_wake_out, 32'h1, "idle wake");
    apb(1, `CANSIP_OFS_PEND, 32'h8000);
    cc(5'h03);
    apb(1, `CANSIP_OFS_PEND, 32'h0002);
    cc(5'h07);
    evt(15'h0000, 1'b1, 1'b0);
    chk(interrupt_code_out, 32'h01, "status");
    apb(1, `CANSIP_OFS_STAT, 32'h0);
    cc(5'h01);
    apb(0, `CANSIP_OFS_STAT, 32'h0);
    chk(rd, 32'h00, "status cleared");
    cc(5'h07);
    apb(1, `CANSIP_OFS_CTRL, 32'h0C);
    wt(2);
    chk(irq_out, 32'h0, "irq off");
    apb(1, `CANSIP_OFS_PEND, 32'h0020);
    cc(5'h00);
    apb(1, `CANSIP_OFS_CTRL, 32'h08);
    evt(15'h0000, 1'b1, 1'b0);
    chk(interrupt_code_out, 32'h00, "no status");
    evt(15'h0000, 1'b0, 1'b1);
    chk(interrupt_code_out, 32'h01, "error");
    apb(0, `CANSIP_OFS_STAT, 32'h0);
    chk(rd, 32'h90, "bus_off_flag flag");
    cc(5'h00);
    apb(1, `CANSIP_OFS_CTRL, 32'h04);
    @(posedge mclk_in);
    lec_upd_in <= 1'b1;
    last_error_code_in <= 3'h5;
    transmit_ok_in <= 1'b1;
    @(posedge mclk_in);
    lec_upd_in <= 1'b0;
    transmit_ok_in <= 1'b0;
    cc(5'h01);
    apb(0, `CANSIP_OFS_STAT, 32'h0);
    chk(rd, 32'h9D, "status flags");
    cc(5'h00);
    end_sim();
  end
endmodule
